// >>> core/iafs_timer.sv
// Down-counting procedure timer with a one-cycle expiry pulse
`timescale 1ns/1ns
module iafs_timer (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       start,
	input  wire logic [iafs_pkg::TMR_W-1:0] count,
	output logic                            running,
	output logic                            done
);
	logic [iafs_pkg::TMR_W-1:0] cnt_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (start) begin
			cnt_reg <= count;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	assign running = (cnt_reg != '0);
	assign done    = (cnt_reg == {{(iafs_pkg::TMR_W-1){1'b0}}, 1'b1});
endmodule

// >>> core/iafs_top.sv
// Flash erase/write sequencer: register slave, unlock check, page erase and program
`timescale 1ns/1ns
module iafs_top #(
	parameter logic [iafs_pkg::TMR_W-1:0] OP_CYCLES     = iafs_pkg::OP_CYCLES,
	parameter logic [iafs_pkg::TMR_W-1:0] UNLOCK_CYCLES = iafs_pkg::UNLOCK_CYCLES
) (
	input  wire logic                            CLK_SYS,
	input  wire logic                            RST_B,
	input  wire logic [iafs_pkg::AV_ADDR_W-1:0]  AVS_ADDRESS,
	input  wire logic                            AVS_READ,
	input  wire logic                            AVS_WRITE,
	input  wire logic [3:0]                      AVS_BYTEENABLE,
	input  wire logic [31:0]                     AVS_WRITEDATA,
	output logic      [31:0]                     AVS_READDATA,
	output logic                                 AVS_WAITREQUEST,
	output logic                                 CPU_HALT,
	output logic                                 FLASH_ERASE,
	output logic                                 FLASH_PROG,
	output logic      [iafs_pkg::PAGE_W-1:0]     FLASH_PAGE,
	input  wire logic [iafs_pkg::BUF_IDX_W-1:0]  FLASH_RD_IDX,
	output logic      [15:0]                     FLASH_RD_DATA
);
	logic                               rst_meta_reg;
	logic                               rst_n;
	iafs_pkg::iafs_state_e              state_reg;
	iafs_pkg::iafs_state_e              state_next;
	logic [2:0]                         mode_reg;
	logic                               enabled_reg;
	logic [iafs_pkg::FLASH_ADDR_W-1:0]  addr_reg;
	logic [7:0]                         w1_lo_reg;
	logic [7:0]                         w1_hi_reg;
	logic [7:0]                         key_reg [iafs_pkg::KEY_BYTES];
	logic [2:0]                         seq_reg;
	logic                               key_bad_reg;
	logic [iafs_pkg::PAGE_W-1:0]        page_reg;
	logic                               rd_valid_reg;
	logic [31:0]                        rdata_reg;
	logic [31:0]                        rdata_next;
	logic                               wr;
	logic [7:0]                         wbyte;
	logic [2:0]                         wmode;
	logic                               key_hit;
	logic [5:0]                         key_ofs;
	logic [2:0]                         key_idx;
	logic                               trig_go;
	logic                               start_go;
	logic                               unlock_done;
	logic                               unlock_ok;
	logic                               op_done;
	logic                               clearing;
	logic                               load_word;
	logic                               relock;

	// Reset release through two flops
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// Only byte lane 0 carries register data; other lanes are ignored
	assign wr      = AVS_WRITE && AVS_BYTEENABLE[0];
	assign wbyte   = AVS_WRITEDATA[7:0];
	assign wmode   = wbyte[iafs_pkg::MODE_LSB +: 3];
	assign key_hit = (AVS_ADDRESS >= iafs_pkg::OFS_KEY_BASE) && (AVS_ADDRESS <= iafs_pkg::OFS_KEY_LAST)
		&& (AVS_ADDRESS[1:0] == 2'b00);
	assign key_ofs = AVS_ADDRESS - iafs_pkg::OFS_KEY_BASE;
	assign key_idx = key_ofs[4:2];

	// Unlock only from the mode written in the same access
	assign trig_go  = wr && (AVS_ADDRESS == iafs_pkg::OFS_CTRL0) && wbyte[iafs_pkg::TRIG_BIT]
		&& (wmode == iafs_pkg::MODE_UNLOCK) && (state_reg == iafs_pkg::ST_IDLE);
	assign start_go = wr && (AVS_ADDRESS == iafs_pkg::OFS_CTRL0) && wbyte[iafs_pkg::START_BIT]
		&& enabled_reg && !clearing && (state_reg == iafs_pkg::ST_IDLE)
		&& ((wmode == iafs_pkg::MODE_ERASE) || (wmode == iafs_pkg::MODE_WRITE));
	assign relock   = wr && (AVS_ADDRESS == iafs_pkg::OFS_CTRL0) && !wbyte[iafs_pkg::EN_BIT];
	assign unlock_ok = unlock_done && (state_reg == iafs_pkg::ST_UNLOCK)
		&& (seq_reg == 3'(iafs_pkg::KEY_BYTES)) && !key_bad_reg;
	assign load_word = wr && (AVS_ADDRESS == iafs_pkg::OFS_W1_HI) && (state_reg == iafs_pkg::ST_IDLE);

	iafs_timer u_unlock_tmr (
		.clk     (CLK_SYS),
		.rst_n   (rst_n),
		.start   (trig_go),
		.count   (UNLOCK_CYCLES),
		.running (),
		.done    (unlock_done)
	);

	iafs_timer u_op_tmr (
		.clk     (CLK_SYS),
		.rst_n   (rst_n),
		.start   (start_go),
		.count   (OP_CYCLES),
		.running (),
		.done    (op_done)
	);

	iafs_wbuf u_wbuf (
		.clk       (CLK_SYS),
		.rst_n     (rst_n),
		.we        (load_word),
		.widx      (addr_reg[iafs_pkg::BUF_IDX_W-1:0]),
		.wdata     ({wbyte, w1_lo_reg}),
		.clr_start (wr && (AVS_ADDRESS == iafs_pkg::OFS_CTRL2) && wbyte[iafs_pkg::CLR_BIT]),
		.ridx      (FLASH_RD_IDX),
		.rdata     (FLASH_RD_DATA),
		.clearing  (clearing)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			iafs_pkg::ST_IDLE: begin
				if (trig_go) begin
					state_next = iafs_pkg::ST_UNLOCK;
				end else if (start_go && (wmode == iafs_pkg::MODE_ERASE)) begin
					state_next = iafs_pkg::ST_ERASE;
				end else if (start_go) begin
					state_next = iafs_pkg::ST_PROG;
				end
			end
			iafs_pkg::ST_UNLOCK: begin
				if (unlock_done) begin
					state_next = iafs_pkg::ST_IDLE;
				end
			end
			iafs_pkg::ST_ERASE, iafs_pkg::ST_PROG: begin
				if (op_done) begin
					state_next = iafs_pkg::ST_IDLE;
				end
			end
			default: state_next = iafs_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= iafs_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg <= iafs_pkg::MODE_RST;
		end else if (wr && (AVS_ADDRESS == iafs_pkg::OFS_CTRL0)) begin
			mode_reg <= wmode;
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			enabled_reg <= 1'b0;
		end else if (unlock_ok) begin
			enabled_reg <= 1'b1;
		end else if (relock) begin
			enabled_reg <= 1'b0;
		end
	end

	// Key bytes must arrive in register order with the right values
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			seq_reg     <= 3'h0;
			key_bad_reg <= 1'b0;
		end else if (trig_go) begin
			seq_reg     <= 3'h0;
			key_bad_reg <= 1'b0;
		end else if (wr && key_hit && (state_reg == iafs_pkg::ST_UNLOCK)) begin
			if ((key_idx == seq_reg) && (seq_reg < 3'(iafs_pkg::KEY_BYTES))
				&& (wbyte == iafs_pkg::KEY_PATTERN[8*seq_reg +: 8])) begin
				seq_reg <= seq_reg + 3'h1;
			end else begin
				key_bad_reg <= 1'b1;
			end
		end
	end

	generate
		for (genvar g = 0; g < iafs_pkg::KEY_BYTES; g++) begin : g_key
			always_ff @(posedge CLK_SYS or negedge rst_n) begin
				if (!rst_n) begin
					key_reg[g] <= iafs_pkg::BYTE_RST;
				end else if (wr && key_hit && (key_idx == 3'(g))) begin
					key_reg[g] <= wbyte;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			w1_lo_reg <= iafs_pkg::BYTE_RST;
			w1_hi_reg <= iafs_pkg::BYTE_RST;
		end else if (wr && (AVS_ADDRESS == iafs_pkg::OFS_W1_LO)) begin
			w1_lo_reg <= wbyte;
		end else if (wr && (AVS_ADDRESS == iafs_pkg::OFS_W1_HI)) begin
			w1_hi_reg <= wbyte;
		end
	end

	// Page boundary holds the address so the buffer never wraps
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg <= iafs_pkg::ADDR_RST;
		end else if (wr && (AVS_ADDRESS == iafs_pkg::OFS_ADDR_LO)) begin
			addr_reg[7:0] <= wbyte;
		end else if (wr && (AVS_ADDRESS == iafs_pkg::OFS_ADDR_HI)) begin
			addr_reg[12:8] <= wbyte[4:0];
		end else if (load_word && (addr_reg[iafs_pkg::BUF_IDX_W-1:0] != '1)) begin
			addr_reg <= addr_reg + 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			page_reg <= '0;
		end else if (start_go) begin
			page_reg <= addr_reg[iafs_pkg::FLASH_ADDR_W-1:iafs_pkg::BUF_IDX_W];
		end
	end

	// Flash strobes come straight from one-hot state flops; CPU halt is their OR
	assign FLASH_ERASE = state_reg[2];
	assign FLASH_PROG  = state_reg[3];
	assign CPU_HALT    = FLASH_ERASE || FLASH_PROG;
	assign FLASH_PAGE  = page_reg;

	always_comb begin
		rdata_next = 32'h00000000;
		case (AVS_ADDRESS)
			iafs_pkg::OFS_CTRL0:   rdata_next[7:0] = {enabled_reg, mode_reg, state_reg[1], CPU_HALT, 2'b00};
			iafs_pkg::OFS_CTRL2:   rdata_next[0]   = clearing;
			iafs_pkg::OFS_ADDR_LO: rdata_next[7:0] = addr_reg[7:0];
			iafs_pkg::OFS_ADDR_HI: rdata_next[4:0] = addr_reg[12:8];
			iafs_pkg::OFS_W1_LO:   rdata_next[7:0] = w1_lo_reg;
			iafs_pkg::OFS_W1_HI:   rdata_next[7:0] = w1_hi_reg;
			default: begin
				if (key_hit) begin
					rdata_next[7:0] = key_reg[key_idx];
				end
			end
		endcase
	end

	// One wait state on reads; writes complete with no wait
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid_reg <= 1'b0;
			rdata_reg    <= 32'h00000000;
		end else begin
			rd_valid_reg <= AVS_READ && !rd_valid_reg;
			if (AVS_READ && !rd_valid_reg) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	assign AVS_WAITREQUEST = AVS_READ && !rd_valid_reg;
	assign AVS_READDATA    = rdata_reg;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!rst_n);

	property p_en_by_hw;
		$rose(enabled_reg) |-> $past(unlock_ok);
	endproperty
	a_en_by_hw: assert property (p_en_by_hw) else $error("enabled set without valid unlock");

	property p_trig_clear;
		(state_reg == iafs_pkg::ST_UNLOCK) && unlock_done |=> (state_reg != iafs_pkg::ST_UNLOCK);
	endproperty
	a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared at timeout");

	property p_bad_key;
		unlock_done && key_bad_reg && !enabled_reg |=> !enabled_reg;
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("wrong key enabled erase/write");

	property p_good_key;
		unlock_ok |=> enabled_reg;
	endproperty
	a_good_key: assert property (p_good_key) else $error("correct key did not enable");

	property p_relock;
		relock && !unlock_ok |=> !enabled_reg;
	endproperty
	a_relock: assert property (p_relock) else $error("relock ignored");

	property p_locked_no_op;
		$rose(CPU_HALT) |-> $past(enabled_reg);
	endproperty
	a_locked_no_op: assert property (p_locked_no_op) else $error("operation started while locked");

	property p_op_hold;
		$rose(CPU_HALT) |-> CPU_HALT[*8];
	endproperty
	a_op_hold: assert property (p_op_hold) else $error("operation ended too soon");

	property p_halt_mode;
		$rose(FLASH_ERASE) |-> $past(wmode) == iafs_pkg::MODE_ERASE;
	endproperty
	a_halt_mode: assert property (p_halt_mode) else $error("erase without erase mode");

	property p_addr_inc;
		load_word && (addr_reg[4:0] != 5'h1F) |=> addr_reg == $past(addr_reg) + 13'h0001;
	endproperty
	a_addr_inc: assert property (p_addr_inc) else $error("address did not advance");

	property p_addr_stop;
		load_word && (addr_reg[4:0] == 5'h1F) |=> $stable(addr_reg);
	endproperty
	a_addr_stop: assert property (p_addr_stop) else $error("address passed page end");

	property p_clr_done;
		$rose(clearing) |-> ##[30:34] !clearing;
	endproperty
	a_clr_done: assert property (p_clr_done) else $error("buffer clear did not finish");
endmodule

// >>> core/iafs_wbuf.sv
// One-page write buffer with a walking clear process
`timescale 1ns/1ns
module iafs_wbuf (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           we,
	input  wire logic [iafs_pkg::BUF_IDX_W-1:0] widx,
	input  wire logic [15:0]                    wdata,
	input  wire logic                           clr_start,
	input  wire logic [iafs_pkg::BUF_IDX_W-1:0] ridx,
	output logic      [15:0]                    rdata,
	output logic                                clearing
);
	logic [15:0]                    mem [iafs_pkg::PAGE_WORDS];
	logic [iafs_pkg::BUF_IDX_W-1:0] clr_idx_reg;

	// Clearing also runs once after reset so every word reads zero after the 32-cycle walk
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clearing    <= 1'b1;
			clr_idx_reg <= '0;
		end else if (clr_start && !clearing) begin
			clearing    <= 1'b1;
			clr_idx_reg <= '0;
		end else if (clearing) begin
			clr_idx_reg <= clr_idx_reg + 1'b1;
			if (clr_idx_reg == '1) begin
				clearing <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (clearing) begin
			mem[clr_idx_reg] <= iafs_pkg::WORD_RST;
		end else if (we) begin
			mem[widx] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= iafs_pkg::WORD_RST;
		end else begin
			rdata <= mem[ridx];
		end
	end
endmodule

// >>> inc/iafs_pkg.sv
// Constants, register map and state encoding for the flash erase/write sequencer
// Summary of operation
// - Mode 110 then unlock trigger bit starts the internal unlock procedure timer.
// - Timer expiry clears the unlock trigger bit whatever keys were written.
// - Wrong key bytes leave erase and write locked; software repeats unlock.
// - Correct key sets the enabled status bit; erase and write then accepted.
// - Software clears the enabled bit to relock, without any key sequence.
// - Erase or write requests without successful unlock never touch the flash.
// - Write buffer is 32 words, one page, chosen by address bits 12 to 5.
// - Each loaded word below the last word of the page advances the write buffer address by one.
// - Buffer address stops at the last word of the page, no wrap.
// - Mode 001 with start bit erases the addressed page; hardware clears start.
// - Mode 000 with start bit programs the buffer; hardware clears start.
// - Erase or write lasts typically 2.2 ms from start set to start clear.
// - CPU is halted while an accepted erase or write is running.
// - On failed write verify, buffer clear empties the buffer before reload.
// - Key word registers hold 16 bits; high byte holds bits 15..8, resets zero.
// - Word1 high write loads the 16-bit word and increments the flash address, except at the last word of the page.
// - Software writing one to the enabled bit has no effect.
// - Buffer clear bit is set by software, cleared by hardware when done.
package iafs_pkg;

	localparam int          AV_ADDR_W      = 6;
	localparam int          FLASH_ADDR_W   = 13;
	localparam int          BUF_IDX_W      = 5;
	localparam int          PAGE_W         = 8;
	localparam int          PAGE_WORDS     = 32;
	localparam int          TMR_W          = 18;
	localparam int          KEY_BYTES      = 6;

	localparam logic [5:0]  OFS_CTRL0      = 6'h00;
	localparam logic [5:0]  OFS_CTRL2      = 6'h04;
	localparam logic [5:0]  OFS_ADDR_LO    = 6'h08;
	localparam logic [5:0]  OFS_ADDR_HI    = 6'h0C;
	localparam logic [5:0]  OFS_W1_LO      = 6'h10;
	localparam logic [5:0]  OFS_W1_HI      = 6'h14;
	localparam logic [5:0]  OFS_KEY_BASE   = 6'h18;
	localparam logic [5:0]  OFS_KEY_LAST   = 6'h2C;

	localparam int          EN_BIT         = 7;
	localparam int          MODE_LSB       = 4;
	localparam int          TRIG_BIT       = 3;
	localparam int          START_BIT      = 2;
	localparam int          CLR_BIT        = 0;

	localparam logic [2:0]  MODE_WRITE     = 3'h0;
	localparam logic [2:0]  MODE_ERASE     = 3'h1;
	localparam logic [2:0]  MODE_UNLOCK    = 3'h6;

	// Byte i of the key belongs to key register i (word2 low first)
	localparam logic [47:0] KEY_PATTERN    = 48'h40C3090D0400;

	localparam logic [7:0]  BYTE_RST       = 8'h00;
	localparam logic [2:0]  MODE_RST       = 3'h0;
	localparam logic [12:0] ADDR_RST       = 13'h0000;
	localparam logic [15:0] WORD_RST       = 16'h0000;

	localparam logic [TMR_W-1:0] UNLOCK_CYCLES = 18'h00040;
	localparam int          OP_TIME_NS     = 2_200_000;
	localparam int          CLK_PERIOD_NS  = 10;
	localparam logic [TMR_W-1:0] OP_CYCLES = TMR_W'(OP_TIME_NS / CLK_PERIOD_NS);

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_UNLOCK = 4'b0010,
		ST_ERASE  = 4'b0100,
		ST_PROG   = 4'b1000
	} iafs_state_e;

endpackage

// >>> testbench/iafs_flash_model.sv
// Behavioural program flash page standing behind the sequencer
`timescale 1ns/1ns
module iafs_flash_model (
	input  wire logic        clk,
	input  wire logic        erase,
	input  wire logic        prog,
	input  wire logic        halt,
	input  wire logic [7:0]  page,
	output logic      [4:0]  rd_idx,
	input  wire logic [15:0] rd_data
);
	// Page starts unknown so only a real erase makes it read zero
	logic [15:0] mem [0:31];
	logic [4:0]  idx_reg = 5'h00;
	logic [4:0]  idx_d = 5'h00;
	logic        prog_d = 1'b0;
	logic        busy_d = 1'b0;
	logic [7:0]  last_page = 8'h00;
	int          n_erase = 0;
	int          n_prog = 0;
	int          busy_cyc = 0;
	int          halt_cyc = 0;

	assign rd_idx = idx_reg;

	always @(posedge clk) begin
		busy_d <= erase | prog;
		prog_d <= prog;
		idx_d  <= idx_reg;
		if ((erase | prog) && !busy_d) begin
			last_page <= page;
			if (erase) begin
				n_erase++;
			end else begin
				n_prog++;
			end
		end
		if (erase | prog) begin
			busy_cyc++;
		end
		if (halt) begin
			halt_cyc++;
		end
		// Walk the buffer once per program; data lags the index by one cycle
		if (!prog) begin
			idx_reg <= 5'h00;
		end else if (idx_reg != 5'h1F) begin
			idx_reg <= idx_reg + 5'h01;
		end
		if (erase) begin
			for (int i = 0; i < 32; i++) begin
				mem[i] <= 16'h0000;
			end
		end
		if (prog_d) begin
			mem[idx_d] <= rd_data;
		end
	end
endmodule

// >>> testbench/tb_iafs_top.sv
// Register-level testbench for the flash erase/write sequencer
`timescale 1ns/1ns
module tb_iafs_top;
	localparam logic [17:0] T_OP    = 18'h00028;
	localparam logic [17:0] T_UNL   = 18'h00014;
	localparam logic [47:0] KEY_OK  = 48'h40C3090D0400;
	localparam logic [47:0] KEY_BAD = 48'h40C3090D0500;

	logic        CLK_SYS;
	logic        RST_B;
	logic [5:0]  AVS_ADDRESS;
	logic        AVS_READ;
	logic        AVS_WRITE;
	logic [3:0]  AVS_BYTEENABLE;
	logic [31:0] AVS_WRITEDATA;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic        CPU_HALT;
	logic        FLASH_ERASE;
	logic        FLASH_PROG;
	logic [7:0]  FLASH_PAGE;
	logic [4:0]  FLASH_RD_IDX;
	logic [15:0] FLASH_RD_DATA;
	int          n_mismatch = 0;
	int          num_checks = 0;

	iafs_top #(.OP_CYCLES(T_OP), .UNLOCK_CYCLES(T_UNL)) DUT (
		.CLK_SYS         (CLK_SYS),
		.RST_B           (RST_B),
		.AVS_ADDRESS     (AVS_ADDRESS),
		.AVS_READ        (AVS_READ),
		.AVS_WRITE       (AVS_WRITE),
		.AVS_BYTEENABLE  (AVS_BYTEENABLE),
		.AVS_WRITEDATA   (AVS_WRITEDATA),
		.AVS_READDATA    (AVS_READDATA),
		.AVS_WAITREQUEST (AVS_WAITREQUEST),
		.CPU_HALT        (CPU_HALT),
		.FLASH_ERASE     (FLASH_ERASE),
		.FLASH_PROG      (FLASH_PROG),
		.FLASH_PAGE      (FLASH_PAGE),
		.FLASH_RD_IDX    (FLASH_RD_IDX),
		.FLASH_RD_DATA   (FLASH_RD_DATA)
	);

	iafs_flash_model FLASH (
		.clk     (CLK_SYS),
		.erase   (FLASH_ERASE),
		.prog    (FLASH_PROG),
		.halt    (CPU_HALT),
		.page    (FLASH_PAGE),
		.rd_idx  (FLASH_RD_IDX),
		.rd_data (FLASH_RD_DATA)
	);

	initial begin
		CLK_SYS = 1'b0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Waitrequest and read data taken at the rising edge that ends the request
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		AVS_ADDRESS   <= a;
		AVS_WRITEDATA <= {24'h000000, d};
		AVS_WRITE     <= 1'b1;
		do begin
			@(posedge CLK_SYS);
		end while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE <= 1'b0;
		@(posedge CLK_SYS);
	endtask

	task automatic rdr(input logic [5:0] a, output logic [31:0] d);
		AVS_ADDRESS <= a;
		AVS_READ    <= 1'b1;
		do begin
			@(posedge CLK_SYS);
		end while (AVS_WAITREQUEST !== 1'b0);
		d = AVS_READDATA;
		AVS_READ <= 1'b0;
		@(posedge CLK_SYS);
	endtask

	task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rdr(a, d);
		chk(d, exp);
	endtask

	task automatic rbit(input logic [5:0] a, input int b, input logic exp);
		logic [31:0] d;
		rdr(a, d);
		chk({31'h0, d[b]}, {31'h0, exp});
	endtask

	// Bounded wait for a self-clearing bit
	task automatic poll(input logic [5:0] a, input int b);
		logic [31:0] d;
		int          i;
		i = 0;
		do begin
			rdr(a, d);
			i++;
		end while (d[b] !== 1'b0 && i < 100);
		chk({31'h0, d[b]}, 32'h0);
	endtask

	task automatic unlock(input logic [47:0] key);
		wr(6'h00, 8'h68);
		rbit(6'h00, 3, 1'b1);
		for (int i = 0; i < 6; i++) begin
			wr(6'h18 + 6'(4 * i), key[8 * i +: 8]);
		end
		poll(6'h00, 3);
	endtask

	initial begin
		RST_B          = 1'b0;
		AVS_ADDRESS    = 6'h00;
		AVS_READ       = 1'b0;
		AVS_WRITE      = 1'b0;
		AVS_BYTEENABLE = 4'hF;
		AVS_WRITEDATA  = 32'h0;
		repeat (5) @(posedge CLK_SYS);
		RST_B <= 1'b1;
		// Buffer self-clears after reset
		repeat (40) @(posedge CLK_SYS);
		for (int i = 0; i < 6; i++) begin
			rchk(6'h18 + 6'(4 * i), 32'h0);
		end
		AVS_BYTEENABLE <= 4'hE;
		wr(6'h20, 8'h5A);
		AVS_BYTEENABLE <= 4'hF;
		rchk(6'h20, 32'h0);
		wr(6'h1C, 8'hA5);
		rchk(6'h1C, 32'h000000A5);
		wr(6'h30, 8'hFF);
		rchk(6'h30, 32'h0);
		wr(6'h00, 8'h94);
		rbit(6'h00, 7, 1'b0);
		chk(32'(FLASH.n_erase), 32'h0);
		unlock(KEY_BAD);
		rbit(6'h00, 7, 1'b0);
		unlock(KEY_OK);
		rbit(6'h00, 7, 1'b1);
		wr(6'h08, 8'hBE);
		wr(6'h0C, 8'h05);
		wr(6'h00, 8'h94);
		rbit(6'h00, 2, 1'b1);
		poll(6'h00, 2);
		chk(32'(FLASH.n_erase), 32'h1);
		chk({24'h0, FLASH.last_page}, 32'h2D);
		chk(32'(FLASH.busy_cyc), 32'(T_OP));
		chk(32'(FLASH.halt_cyc), 32'(T_OP));
		for (int i = 0; i < 32; i++) begin
			chk({16'h0, FLASH.mem[i]}, 32'h0);
		end
		wr(6'h10, 8'h34);
		wr(6'h14, 8'h12);
		wr(6'h10, 8'hEF);
		wr(6'h14, 8'hBE);
		wr(6'h10, 8'hFE);
		wr(6'h14, 8'hCA);
		rchk(6'h08, 32'h000000BF);
		rchk(6'h0C, 32'h00000005);
		wr(6'h00, 8'h84);
		poll(6'h00, 2);
		chk({16'h0, FLASH.mem[30]}, 32'h1234);
		chk({16'h0, FLASH.mem[31]}, 32'hCAFE);
		chk({16'h0, FLASH.mem[0]}, 32'h0);
		chk(32'(FLASH.n_prog), 32'h1);
		chk(32'(FLASH.busy_cyc), 32'(2 * T_OP));
		chk(32'(FLASH.halt_cyc), 32'(2 * T_OP));
		wr(6'h04, 8'h01);
		rbit(6'h04, 0, 1'b1);
		poll(6'h04, 0);
		wr(6'h00, 8'h84);
		poll(6'h00, 2);
		chk({16'h0, FLASH.mem[30]}, 32'h0);
		chk({16'h0, FLASH.mem[31]}, 32'h0);
		wr(6'h00, 8'h00);
		rbit(6'h00, 7, 1'b0);
		wr(6'h00, 8'h84);
		rbit(6'h00, 2, 1'b0);
		chk(32'(FLASH.n_prog), 32'h2);
		summarize();
	end

	// Whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		n_mismatch++;
		summarize();
	end
endmodule
